// [hdl/cbs_pkg.sv]
// Shared constants and types for the bus side-band ends
package cbs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BUSY = 4'h2,
    ST_GRANT = 4'h4,
    ST_BACKOFF_ABORT = 4'h8
  } cbs_state_type;
  localparam logic [2:0] BEATS_ONE = 3'h1;
  localparam logic [2:0] BEATS_LINE = 3'h4;
  localparam logic [1:0] INTA_CYCLES = 2'h2;
  localparam logic [1:0] INTA_LAST = 2'h1;
  localparam logic [1:0] LINE_INVALID = 2'h0;
  localparam logic [1:0] LINE_SHARED = 2'h1;
  localparam logic [7:0] FP_VECTOR = 8'h10;
  localparam logic [31:0] RESTART_ADDR = 32'hffff_fff0;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
endpackage

// [hdl/cbs_link_if.sv]
// Side-band pins between the processor end and the system logic end
`timescale 1ns/10ps
`default_nettype none
interface cbs_link_if;
  logic bus_hold_req;
  logic bus_grant_ack;
  logic burst_ready_in;
  logic pipeline_next_ok;
  logic backoff_abort;
  logic cacheable_ack;
  logic fill_intent;
  logic page_uncached_attr;
  logic addr_strobe;
  logic cycle_write;
  logic cycle_inta;
  logic bus_float;
  logic bus_lock;
  logic bus_lock_oe;
  logic fp_error_ignore;
  logic fp_error_out;
  logic warm_restart;
  logic sys_reset_in;
  logic maskable_irq;
  logic sys_mgmt_irq;
  logic nonmask_irq;
  logic ext_snoop_strobe;
  logic snoop_drop_line;
  logic [7:0] inta_vector;
  // Floated lock reads inactive on the wire
  logic bus_lock_level;
  assign bus_lock_level = bus_lock_oe & bus_lock;
  modport dev (
    input bus_hold_req, burst_ready_in, pipeline_next_ok, backoff_abort, cacheable_ack,
    input fp_error_ignore, warm_restart, sys_reset_in, maskable_irq, sys_mgmt_irq,
    input nonmask_irq, ext_snoop_strobe, snoop_drop_line, inta_vector,
    output bus_grant_ack, fill_intent, page_uncached_attr, addr_strobe, cycle_write,
    output cycle_inta, bus_float, bus_lock, bus_lock_oe, fp_error_out
  );
  modport sys (
    output bus_hold_req, burst_ready_in, pipeline_next_ok, backoff_abort, cacheable_ack,
    output fp_error_ignore, warm_restart, sys_reset_in, maskable_irq, sys_mgmt_irq,
    output nonmask_irq, ext_snoop_strobe, snoop_drop_line, inta_vector,
    input bus_grant_ack, fill_intent, page_uncached_attr, addr_strobe, cycle_write,
    input cycle_inta, bus_float, bus_lock, bus_lock_oe, fp_error_out, bus_lock_level
  );
endinterface
`default_nettype wire

// [hdl/cbs_edge_latch.sv]
// Rising-edge request latch held until consumed
`timescale 1ns/10ps
`default_nettype none
module cbs_edge_latch (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic level,
  input wire logic consume,
  output logic pending
);
  logic prev;
  logic rise;
  assign rise = level & ~prev;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev <= 1'b0;
      pending <= 1'b0;
    end
    else
    begin
      prev <= level;
      // A new edge wins over a consume in the same cycle
      pending <= rise | (pending & ~consume);
    end
  end
endmodule
`default_nettype wire

// [hdl/cbs_device_end.sv]
// Processor end of the bus side-band control
`timescale 1ns/10ps
`default_nettype none
module cbs_device_end (
  input wire logic mclk,
  input wire logic arst_n,
  cbs_link_if.dev link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_fill,
  input wire logic cmd_uncached,
  input wire logic cmd_lock,
  input wire logic cmd_lock_last,
  output logic cmd_taken,
  output logic cycle_done,
  output logic cycle_cached,
  input wire logic insn_boundary,
  input wire logic maskable_irq_enable,
  input wire logic fp_exc_raise,
  input wire logic fp_exc_clear,
  input wire logic fp_target,
  input wire logic fp_target_sensitive,
  input wire logic fp_error_report_mode,
  output logic fp_proceed,
  output logic fp_stall,
  output logic fp_vector_take,
  output logic [7:0] fp_vector,
  output logic irq_service,
  output logic irq_branch,
  output logic [7:0] irq_vector,
  output logic warm_restart_go,
  output logic [31:0] restart_addr,
  input wire logic snoop_hit,
  input wire logic snoop_modified,
  input wire logic wb_done,
  output logic writeback_req,
  output logic line_state_we,
  output logic [1:0] line_state
);
  function automatic logic [2:0] beats_needed(input logic wr, input logic fill, input logic cached);
    beats_needed = (fill & (wr | cached)) ? cbs_pkg::BEATS_LINE : cbs_pkg::BEATS_ONE;
  endfunction

  cbs_pkg::cbs_state_type state;
  cbs_pkg::cbs_state_type next_state;
  logic [2:0] beats_done;
  logic ken_seen;
  logic ken_val;
  logic cur_write;
  logic cur_fill;
  logic cur_unc;
  logic cur_lock_last;
  logic cur_inta;
  logic lock_gap;
  logic [1:0] inta_left;
  logic fp_pend;
  logic snoop_wait;
  logic [1:0] snoop_state;
  logic restart_pend;

  // Cycle source: interrupt acknowledge cycles take precedence
  wire src_inta = inta_left != 2'h0;
  wire src_valid = src_inta | cmd_valid;
  wire src_write = src_inta ? 1'b0 : cmd_write;
  wire src_fill = src_inta ? 1'b0 : cmd_fill;
  wire src_unc = src_inta ? 1'b0 : cmd_uncached;
  wire src_lock = src_inta | cmd_lock;
  wire src_last = src_inta ? (inta_left == cbs_pkg::INTA_LAST) : cmd_lock_last;
  wire start_ok = src_valid & ~(src_lock & lock_gap) & ~link.backoff_abort;
  // Cacheable ack is looked at on the first ready or next-address edge of a fill read
  wire ken_window = ~ken_seen & ~cur_write & cur_fill & (link.burst_ready_in | link.pipeline_next_ok);
  wire cached_now = ken_seen ? ken_val : (link.cacheable_ack & ~cur_unc);
  wire last_beat = link.burst_ready_in
                 & ((beats_done + 3'h1) == beats_needed(cur_write, cur_fill, cached_now));
  wire end_cycle = (state == cbs_pkg::ST_BUSY) & ~link.backoff_abort & last_beat;
  wire lock_drop = end_cycle & cur_lock_last & link.bus_lock;
  wire start_now = (next_state == cbs_pkg::ST_BUSY) & (state != cbs_pkg::ST_BUSY);
  wire fresh_start = start_now & (state == cbs_pkg::ST_IDLE);
  wire next_bus_grant_ack = next_state == cbs_pkg::ST_GRANT;
  wire next_float = next_bus_grant_ack | link.backoff_abort;
  wire stall_break = link.maskable_irq | link.sys_mgmt_irq | link.nonmask_irq | link.warm_restart;
  wire irq_take = insn_boundary & link.maskable_irq & maskable_irq_enable & ~src_inta & ~cur_inta;

  // Hold is never gated by the reset inputs
  always_comb
  begin
    next_state = state;
    case (state)
      cbs_pkg::ST_IDLE:
        if (link.bus_hold_req & ~link.bus_lock)
          next_state = cbs_pkg::ST_GRANT;
        else if (start_ok)
          next_state = cbs_pkg::ST_BUSY;
      cbs_pkg::ST_BUSY:
        if (link.backoff_abort)
          next_state = cbs_pkg::ST_BACKOFF_ABORT;
        else if (last_beat)
          next_state = (link.bus_hold_req & ~(link.bus_lock & ~cur_lock_last))
                     ? cbs_pkg::ST_GRANT : cbs_pkg::ST_IDLE;
      cbs_pkg::ST_BACKOFF_ABORT:
        if (!link.backoff_abort)
          next_state = cbs_pkg::ST_BUSY;
      cbs_pkg::ST_GRANT:
        if (!link.bus_hold_req)
          next_state = cbs_pkg::ST_IDLE;
      default:
        next_state = cbs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= cbs_pkg::ST_IDLE;
      beats_done <= 3'h0;
      ken_seen <= 1'b0;
      ken_val <= 1'b0;
      cur_write <= 1'b0;
      cur_fill <= 1'b0;
      cur_unc <= 1'b0;
      cur_lock_last <= 1'b0;
      cur_inta <= 1'b0;
      cmd_taken <= 1'b0;
      cycle_done <= 1'b0;
      cycle_cached <= 1'b0;
      link.addr_strobe <= 1'b0;
      link.bus_grant_ack <= 1'b0;
      link.bus_float <= 1'b0;
      link.bus_lock <= 1'b0;
      link.bus_lock_oe <= 1'b1;
      link.fill_intent <= 1'b0;
      link.page_uncached_attr <= 1'b0;
      link.cycle_write <= 1'b0;
      link.cycle_inta <= 1'b0;
      lock_gap <= 1'b0;
    end
    else
    begin
      state <= next_state;
      link.bus_grant_ack <= next_bus_grant_ack;
      link.bus_float <= next_float;
      link.bus_lock_oe <= ~next_float;
      link.addr_strobe <= start_now;
      cmd_taken <= fresh_start & ~src_inta;
      cycle_done <= end_cycle;
      lock_gap <= lock_drop;
      if (fresh_start)
      begin
        cur_write <= src_write;
        cur_fill <= src_fill;
        cur_unc <= src_unc;
        cur_lock_last <= src_last;
        cur_inta <= src_inta;
        link.cycle_write <= src_write;
        link.fill_intent <= src_fill;
        link.page_uncached_attr <= src_unc;
        link.cycle_inta <= src_inta;
      end
      if (fresh_start & src_lock)
        link.bus_lock <= 1'b1;
      else if (lock_drop)
        link.bus_lock <= 1'b0;
      if (start_now)
      begin
        beats_done <= 3'h0;
        ken_seen <= 1'b0;
      end
      else if ((state == cbs_pkg::ST_BUSY) & link.burst_ready_in & ~link.backoff_abort)
        beats_done <= beats_done + 3'h1;
      // Later beats and writebacks leave the sampled value alone
      if ((state == cbs_pkg::ST_BUSY) & ken_window & ~link.backoff_abort)
      begin
        ken_seen <= 1'b1;
        ken_val <= link.cacheable_ack & ~cur_unc;
      end
      if (end_cycle)
        cycle_cached <= cached_now & cur_fill & ~cur_write;
      if (end_cycle)
        cur_inta <= 1'b0;
    end
  end

  // Interrupt acknowledge pair and vector capture
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inta_left <= 2'h0;
      irq_branch <= 1'b0;
      irq_vector <= cbs_pkg::VECTOR_RESET;
    end
    else
    begin
      irq_branch <= end_cycle & cur_inta & cur_lock_last;
      if (irq_take)
        inta_left <= cbs_pkg::INTA_CYCLES;
      else if (fresh_start & src_inta)
        inta_left <= inta_left - 2'h1;
      if (end_cycle & cur_inta & cur_lock_last)
        irq_vector <= link.inta_vector;
    end
  end

  // Floating-point error handling at target boundaries
  wire fp_hit = fp_target & fp_pend & fp_target_sensitive;
  wire fp_ignore_now = ~fp_error_report_mode & link.fp_error_ignore;
  wire fp_release = fp_stall & link.fp_error_ignore;
  wire fp_discard = (fp_hit & fp_ignore_now) | fp_release;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fp_pend <= 1'b0;
      fp_stall <= 1'b0;
      fp_proceed <= 1'b0;
      fp_vector_take <= 1'b0;
      fp_vector <= cbs_pkg::VECTOR_RESET;
      irq_service <= 1'b0;
      link.fp_error_out <= 1'b0;
    end
    else
    begin
      // Of the reset inputs only sys_reset_in clears the error state, a warm restart keeps it
      fp_pend <= fp_exc_raise | (fp_pend & ~fp_discard & ~fp_exc_clear & ~link.sys_reset_in);
      if (fp_target & fp_pend)
        link.fp_error_out <= 1'b1;
      else if (fp_exc_clear | link.sys_reset_in)
        link.fp_error_out <= 1'b0;
      fp_vector_take <= fp_hit & fp_error_report_mode;
      fp_vector <= cbs_pkg::FP_VECTOR;
      // Insensitive targets and clean targets run on
      fp_proceed <= (fp_target & ~fp_hit) | (fp_hit & fp_ignore_now) | fp_release;
      irq_service <= fp_stall & ~link.fp_error_ignore & stall_break;
      if (fp_hit & ~fp_error_report_mode & ~link.fp_error_ignore)
        fp_stall <= 1'b1;
      else if (fp_release | stall_break)
        fp_stall <= 1'b0;
    end
  end

  // Warm restart: rising edge held to the next boundary
  cbs_edge_latch u_restart (
    .mclk(mclk),
    .arst_n(arst_n),
    .level(link.warm_restart),
    .consume(insn_boundary),
    .pending(restart_pend)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      warm_restart_go <= 1'b0;
      restart_addr <= cbs_pkg::RESTART_ADDR;
    end
    else
    begin
      warm_restart_go <= restart_pend & insn_boundary;
      restart_addr <= cbs_pkg::RESTART_ADDR;
    end
  end

  // Snoop outcome, modified lines are written back first
  wire snoop_now = link.ext_snoop_strobe & ~snoop_wait;
  wire [1:0] snoop_target = link.snoop_drop_line ? cbs_pkg::LINE_INVALID : cbs_pkg::LINE_SHARED;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      snoop_wait <= 1'b0;
      snoop_state <= cbs_pkg::LINE_SHARED;
      writeback_req <= 1'b0;
      line_state_we <= 1'b0;
      line_state <= cbs_pkg::LINE_SHARED;
    end
    else
    begin
      line_state_we <= (snoop_now & snoop_hit & ~snoop_modified) | (snoop_wait & wb_done);
      if (snoop_now)
        snoop_state <= snoop_target;
      if (snoop_now & snoop_hit & ~snoop_modified)
        line_state <= snoop_target;
      else if (snoop_wait & wb_done)
        line_state <= snoop_state;
      if (snoop_now & snoop_hit & snoop_modified)
      begin
        snoop_wait <= 1'b1;
        writeback_req <= 1'b1;
      end
      else if (snoop_wait & wb_done)
      begin
        snoop_wait <= 1'b0;
        writeback_req <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/cbs_host_end.sv]
// System logic end of the bus side-band control
`timescale 1ns/10ps
`default_nettype none
module cbs_host_end (
  input wire logic mclk,
  input wire logic arst_n,
  cbs_link_if.sys link,
  input wire logic hold_want,
  output logic granted,
  input wire logic backoff_want,
  input wire logic cacheable_want,
  input wire logic [7:0] vector_val,
  input wire logic ignore_fp,
  input wire logic warm_req,
  input wire logic reset_want,
  input wire logic irq_want,
  input wire logic smi_want,
  input wire logic nmi_want,
  input wire logic snoop_go,
  input wire logic snoop_drop,
  output logic irq_pending,
  output logic lock_view
);
  logic busy;
  logic aborted;
  logic ken_hold;
  logic [2:0] beats_left;
  logic [1:0] inta_seen;
  // Same cacheable answer on a restart after backoff
  wire ken_pick = aborted ? ken_hold : cacheable_want;
  wire [2:0] beats_pick = (link.fill_intent & (link.cycle_write | (ken_pick & ~link.page_uncached_attr)))
                        ? cbs_pkg::BEATS_LINE : cbs_pkg::BEATS_ONE;
  wire beat_now = busy & link.burst_ready_in;
  wire beat_last = beat_now & (beats_left == cbs_pkg::BEATS_ONE);
  wire inta_end = beat_last & link.cycle_inta;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'b0;
      aborted <= 1'b0;
      ken_hold <= 1'b0;
      beats_left <= 3'h0;
      link.burst_ready_in <= 1'b0;
      link.cacheable_ack <= 1'b0;
      link.backoff_abort <= 1'b0;
    end
    else
    begin
      link.backoff_abort <= backoff_want;
      if (link.addr_strobe & ~link.backoff_abort)
      begin
        busy <= 1'b1;
        beats_left <= beats_pick;
        ken_hold <= ken_pick;
        link.cacheable_ack <= ken_pick;
        link.burst_ready_in <= ~backoff_want;
        aborted <= 1'b0;
      end
      else if (busy & link.backoff_abort)
      begin
        busy <= 1'b0;
        aborted <= 1'b1;
        link.burst_ready_in <= 1'b0;
      end
      else if (beat_now)
      begin
        beats_left <= beats_left - 3'h1;
        busy <= ~beat_last;
        link.burst_ready_in <= ~beat_last & ~backoff_want;
      end
      else
        link.burst_ready_in <= busy & ~backoff_want;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.bus_hold_req <= 1'b0;
      granted <= 1'b0;
      link.pipeline_next_ok <= 1'b0;
      link.fp_error_ignore <= 1'b0;
      link.warm_restart <= 1'b0;
      link.sys_reset_in <= 1'b0;
      link.maskable_irq <= 1'b0;
      link.sys_mgmt_irq <= 1'b0;
      link.nonmask_irq <= 1'b0;
      link.ext_snoop_strobe <= 1'b0;
      link.snoop_drop_line <= 1'b0;
      link.inta_vector <= cbs_pkg::VECTOR_RESET;
      inta_seen <= 2'h0;
      irq_pending <= 1'b0;
      lock_view <= 1'b0;
    end
    else
    begin
      link.bus_hold_req <= hold_want;
      granted <= link.bus_grant_ack;
      link.pipeline_next_ok <= 1'b0;
      link.fp_error_ignore <= ignore_fp;
      link.warm_restart <= warm_req;
      link.sys_reset_in <= reset_want;
      link.sys_mgmt_irq <= smi_want;
      link.nonmask_irq <= nmi_want;
      link.ext_snoop_strobe <= snoop_go;
      link.snoop_drop_line <= snoop_drop;
      link.inta_vector <= vector_val;
      // Request stays up until both acknowledge cycles finish
      if (irq_pending & inta_end & (inta_seen == cbs_pkg::INTA_LAST))
      begin
        irq_pending <= 1'b0;
        inta_seen <= 2'h0;
      end
      else
      begin
        irq_pending <= irq_pending | irq_want;
        if (inta_end)
          inta_seen <= inta_seen + 2'h1;
      end
      link.maskable_irq <= irq_pending & ~(inta_end & (inta_seen == cbs_pkg::INTA_LAST));
      // Lock condition kept while the pin floats
      if (link.bus_lock_oe)
        lock_view <= link.bus_lock;
    end
  end
endmodule
`default_nettype wire

// [test/cbs_link_assertions.sv]
// Concurrent checks on the side-band link between the two ends
`timescale 1ns/10ps
`default_nettype none
module cbs_link_assertions (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus_hold_req,
  input wire logic bus_grant_ack,
  input wire logic burst_ready_in,
  input wire logic backoff_abort,
  input wire logic addr_strobe,
  input wire logic cycle_inta,
  input wire logic bus_float,
  input wire logic bus_lock,
  input wire logic bus_lock_oe
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  hold_drop_a: assert property (!bus_hold_req |=> !bus_grant_ack)
    else $error("grant stayed after hold was low");
  grant_cause_a: assert property ($rose(bus_grant_ack) |-> $past(bus_hold_req))
    else $error("grant rose without hold");
  grant_stands_a: assert property (bus_grant_ack && bus_hold_req |=> bus_grant_ack)
    else $error("grant dropped while hold high");
  grant_float_a: assert property (bus_grant_ack |-> bus_float && !bus_lock_oe && !addr_strobe)
    else $error("bus driven while granted");
  backoff_abort_float_a: assert property (backoff_abort |=> bus_float && !bus_lock_oe)
    else $error("bus driven after backoff");
  float_cause_a: assert property (bus_float |-> bus_grant_ack || $past(backoff_abort))
    else $error("bus floated without cause");
  lock_strobe_a: assert property ($rose(bus_lock) |-> addr_strobe ##1 !addr_strobe)
    else $error("lock rose apart from strobe");
  lock_release_a: assert property ($fell(bus_lock) |-> $past(burst_ready_in) && !addr_strobe)
    else $error("lock dropped off a ready edge");
  inta_lock_a: assert property (addr_strobe && cycle_inta |-> bus_lock)
    else $error("acknowledge cycle not locked");
endmodule
`default_nettype wire

// [test/tb.sv]
// Testbench joining the processor end and the system end
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic cmd_valid = 1'h0, cmd_write = 1'h0, cmd_fill = 1'h0, cmd_uncached = 1'h0, cmd_lock = 1'h0;
  logic cmd_lock_last = 1'h0, insn_boundary = 1'h0, maskable_irq_enable = 1'h0, fp_exc_raise = 1'h0;
  logic fp_exc_clear = 1'h0, fp_target = 1'h0, fp_target_sensitive = 1'h0, fp_error_report_mode = 1'h0;
  logic snoop_hit = 1'h0, snoop_modified = 1'h0, wb_done = 1'h0, hold_want = 1'h0, backoff_want = 1'h0;
  logic cacheable_want = 1'h0, ignore_fp = 1'h0, warm_req = 1'h0, reset_want = 1'h0, irq_want = 1'h0;
  logic snoop_go = 1'h0, snoop_drop = 1'h0, nmi_want = 1'h0;
  logic [7:0] vector_val = 8'h00;
  logic cmd_taken, cycle_done, cycle_cached, fp_proceed, fp_stall, fp_vector_take, irq_service;
  logic irq_branch, warm_restart_go, writeback_req, line_state_we, granted, irq_pending, lock_view;
  logic [7:0] fp_vector, irq_vector;
  logic [31:0] restart_addr;
  logic [1:0] line_state;
  logic h, t;
  int num_errors = 0;
  int n_compared = 0;
  int n, k;
  // Beat table: cacheable, write, fill, uncached, lock, lock_last, beats
  localparam logic [8:0] BT [5] = '{9'h144, 9'h041, 9'h161, 9'h101, 9'h081};
  cbs_link_if link ();
  cbs_device_end i_cbs_device_end (.mclk, .arst_n, .link(link), .cmd_valid, .cmd_write, .cmd_fill,
    .cmd_uncached, .cmd_lock, .cmd_lock_last, .cmd_taken, .cycle_done, .cycle_cached, .insn_boundary,
    .maskable_irq_enable, .fp_exc_raise, .fp_exc_clear, .fp_target, .fp_target_sensitive, .fp_error_report_mode,
    .fp_proceed, .fp_stall, .fp_vector_take, .fp_vector, .irq_service, .irq_branch, .irq_vector,
    .warm_restart_go, .restart_addr, .snoop_hit, .snoop_modified, .wb_done, .writeback_req,
    .line_state_we, .line_state);
  cbs_host_end i_cbs_host_end (.mclk, .arst_n, .link(link), .hold_want, .granted, .backoff_want,
    .cacheable_want, .vector_val, .ignore_fp, .warm_req, .reset_want, .irq_want, .smi_want(1'h0),
    .nmi_want, .snoop_go, .snoop_drop, .irq_pending, .lock_view);
  cbs_link_assertions i_cbs_link_assertions (.mclk(mclk), .arst_n(arst_n),
    .bus_hold_req(link.bus_hold_req), .bus_grant_ack(link.bus_grant_ack),
    .burst_ready_in(link.burst_ready_in), .backoff_abort(link.backoff_abort), .addr_strobe(link.addr_strobe),
    .cycle_inta(link.cycle_inta), .bus_float(link.bus_float), .bus_lock(link.bus_lock),
    .bus_lock_oe(link.bus_lock_oe));
  always #4 mclk = ~mclk;
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic watch(ref logic s, input int c, output logic hit);
    hit = 1'h0;
    repeat (c)
    begin
      hit = hit | (s === 1'h1);
      tick(1);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    arst_n = 1'h0;
    tick(4);
    arst_n = 1'h1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  // Present a command and hold it until taken
  task automatic start(input logic [4:0] m);
    {cmd_write, cmd_fill, cmd_uncached, cmd_lock, cmd_lock_last} = m;
    cmd_valid = 1'h1;
    k = 0;
    while (cmd_taken !== 1'h1 && k < 50)
    begin
      tick(1);
      k++;
    end
    cmd_valid = 1'h0;
  endtask
  // Count ready beats until the cycle completes
  task automatic finish();
    n = 0;
    k = 0;
    while (cycle_done !== 1'h1 && k < 60)
    begin
      n += (link.burst_ready_in === 1'h1);
      tick(1);
      k++;
    end
    chk("cycle_done", 1, cycle_done);
  endtask
  task automatic sc_beats();
    foreach (BT[i])
    begin
      cacheable_want = BT[i][8];
      tick(2);
      start(BT[i][7:3]);
      finish();
      chk("beats", BT[i][2:0], n);
      chk("cycle_cached", i == 0, cycle_cached);
    end
  endtask
  task automatic sc_hold();
    cacheable_want = 1'h1;
    start(5'h08);
    hold_want = 1'h1;
    finish();
    chk("grant_busy", 1, link.bus_grant_ack);
    hold_want = 1'h0;
    tick(4);
    hold_want = 1'h1;
    tick(1);
    chk("grant_early", 0, link.bus_grant_ack);
    tick(1);
    chk("grant_idle", 1, link.bus_grant_ack);
    chk("float", 1, link.bus_float);
    hold_want = 1'h0;
    tick(1);
    chk("grant_stand", 1, link.bus_grant_ack);
    chk("granted", 1, granted);
    tick(1);
    chk("grant_drop", 0, link.bus_grant_ack);
    reset_want = 1'h1;
    warm_req = 1'h1;
    hold_want = 1'h1;
    tick(3);
    chk("grant_reset", 1, link.bus_grant_ack);
    {reset_want, warm_req, hold_want} = 3'h0;
    tick(3);
    do_reset();
  endtask
  task automatic sc_lock();
    start(5'h02);
    finish();
    chk("lock_mid", 1, link.bus_lock);
    start(5'h0b);
    tick(1);
    backoff_want = 1'h1;
    tick(1);
    backoff_want = 1'h0;
    tick(1);
    chk("backoff_abort_float", 1, link.bus_float);
    chk("lock_wire", 0, link.bus_lock_level);
    chk("lock_kept", 1, lock_view);
    finish();
    tick(1);
    chk("lock_end", 0, link.bus_lock);
  endtask
  // Sensitive, report mode, ignore; expected vector take and stall
  task automatic fp_case(input logic [2:0] c, input logic [1:0] e);
    {fp_target_sensitive, fp_error_report_mode, ignore_fp} = c;
    pulse(fp_exc_raise);
    tick(3);
    pulse(fp_target);
    t = 1'h0;
    h = 1'h0;
    repeat (4)
    begin
      t = t | (fp_vector_take === 1'h1);
      h = h | (fp_proceed === 1'h1);
      tick(1);
    end
    chk("fp_error_out", 1, link.fp_error_out);
    chk("fp_take_stall", e, {t, fp_stall});
  endtask
  task automatic sc_fp();
    fp_case(3'h6, 2'h2);
    chk("fp_vector", cbs_pkg::FP_VECTOR, fp_vector);
    pulse(fp_exc_clear);
    fp_case(3'h5, 2'h0);
    chk("fp_proceed", 1, h);
    pulse(fp_exc_clear);
    fp_case(3'h0, 2'h0);
    pulse(fp_exc_clear);
    fp_case(3'h4, 2'h1);
    nmi_want = 1'h1;
    watch(irq_service, 6, h);
    chk("stall_nmi", 1, h);
    nmi_want = 1'h0;
    pulse(fp_exc_clear);
    fp_case(3'h4, 2'h1);
    irq_want = 1'h1;
    watch(irq_service, 6, h);
    chk("stall_irq", 1, h);
    irq_want = 1'h0;
    pulse(fp_exc_clear);
    tick(3);
  endtask
  task automatic sc_irq();
    irq_want = 1'h1;
    tick(3);
    pulse(insn_boundary);
    watch(link.addr_strobe, 8, h);
    chk("irq_masked", 0, h);
    maskable_irq_enable = 1'h1;
    vector_val = 8'h5a;
    pulse(insn_boundary);
    n = 0;
    k = 0;
    while (irq_branch !== 1'h1 && k < 40)
    begin
      n += (link.addr_strobe === 1'h1 && link.cycle_inta === 1'h1);
      tick(1);
      k++;
    end
    chk("inta_cycles", 2, n);
    chk("irq_branch", 1, irq_branch);
    chk("irq_pending", 0, irq_pending);
    chk("irq_vector", 8'h5a, irq_vector);
    {irq_want, maskable_irq_enable} = 2'h0;
    tick(3);
  endtask
  task automatic sc_warm();
    pulse(warm_req);
    watch(warm_restart_go, 5, h);
    chk("warm_early", 0, h);
    pulse(insn_boundary);
    watch(warm_restart_go, 3, h);
    chk("warm_go", 1, h);
    chk("restart_addr", cbs_pkg::RESTART_ADDR, restart_addr);
  endtask
  // Drop request, modified hit, expected line state
  task automatic snp(input logic d, input logic m, input logic [1:0] e);
    {snoop_hit, snoop_drop, snoop_modified} = {1'h1, d, m};
    pulse(snoop_go);
    watch(line_state_we, 4, h);
    chk("snoop_we_early", !m, h);
    if (m)
    begin
      chk("writeback", 1, writeback_req);
      chk("line_held", cbs_pkg::LINE_SHARED, line_state);
      pulse(wb_done);
      watch(line_state_we, 3, h);
      chk("snoop_we_late", 1, h);
    end
    chk("line_state", e, line_state);
    snoop_hit = 1'h0;
    tick(2);
  endtask
  initial
  begin
    do_reset();
    sc_beats();
    sc_hold();
    sc_lock();
    sc_fp();
    sc_irq();
    sc_warm();
    snp(1'h1, 1'h0, cbs_pkg::LINE_INVALID);
    snp(1'h0, 1'h0, cbs_pkg::LINE_SHARED);
    snp(1'h1, 1'h1, cbs_pkg::LINE_INVALID);
    close_out();
  end
  initial
  begin
    #40000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
